/* pdt_params.svh */
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH
`define PDT_CTRL_IDX 12'h009
`define PDT_OPT_IDX 12'h7F5
`define PDT_CNT_IDX 12'h008
`define PDT_OPT_PROG_IDX 12'h100
`define PDT_BIT_REQ 7
`define PDT_BIT_MASK 6
`define PDT_BIT_SRC 5
`define PDT_BIT_EXT 4
`define PDT_BIT_PCLR 3
`define PDT_BIT_OSC 7
`define PDT_BIT_DIV 6
`define PDT_BIT_TRIG 4
`define PDT_OPT_UNUSED 8'h2F
`define PDT_OPT_ERASED 8'h00
`define PDT_PRESCALE_W 7
`define PDT_INTCLK_DIV 4
`endif

/* pdt_pin_model.sv */
`timescale 1ns/1ps
module pdt_pin_model (
    input wire logic clock,
    input wire logic [1:0] pinMode,
    output logic pin
);
    logic [3:0] phase = 4'h0;
    initial pin = 1'b0;
    // Mode 2 toggles with a 16-cycle period, so any 64-cycle span holds four falls
    always @(posedge clock) begin
        phase <= phase + 4'h1;
        pin <= (pinMode == 2'h2) ? phase[3] : pinMode[0];
    end
endmodule : pdt_pin_model

/* pdt_pin_sync.sv */
`timescale 1ns/1ps
module pdt_pin_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic pinLevel
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_pinLevel;
    always_comb begin
        next_stage = {stage[1:0], pinIn};
        next_pinLevel = (stage[2] == stage[1]) ? stage[1] : pinLevel;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 3'h0;
            pinLevel <= 1'b0;
        end else begin
            stage <= next_stage;
            pinLevel <= next_pinLevel;
        end
    end
endmodule : pdt_pin_sync

/* pdt_pkg.sv */
package pdt_pkg;
    typedef enum logic [2:0] {
        PDT_RUN = 3'h1,
        PDT_STOPPED = 3'h2,
        PDT_IDLE = 3'h4
    } pdt_state_type;
    typedef enum logic [1:0] {
        PDT_SRC_INT = 2'h0,
        PDT_SRC_AND = 2'h1,
        PDT_SRC_OFF = 2'h2,
        PDT_SRC_PIN = 2'h3
    } pdt_source_type;
endpackage : pdt_pkg

/* pdt_tap_select.sv */
`timescale 1ns/1ps
`include "pdt_params.svh"
module pdt_tap_select (
    input wire logic [`PDT_PRESCALE_W-1:0] prescaleNext,
    input wire logic [`PDT_PRESCALE_W-1:0] prescale,
    input wire logic [2:0] tapSel,
    input wire logic step,
    output logic tapPulse
);
    // Tap k rolls from ones to zeros once per 2^k steps
    logic [`PDT_PRESCALE_W:0] fall;
    assign fall[0] = step;
    genvar g;
    generate
        for (g = 0; g < `PDT_PRESCALE_W; g++) begin : gTap
            assign fall[g+1] = step & prescale[g] & ~prescaleNext[g];
        end
    endgenerate
    assign tapPulse = fall[tapSel];
endmodule : pdt_tap_select

/* pdt_timer.sv */
`timescale 1ns/1ps
`include "pdt_params.svh"
module pdt_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timerPin,
    input wire logic stopExec,
    input wire logic extIrqWake,
    input wire logic cpuIrqMask,
    input wire logic bootstrapMode,
    output logic timerIrq,
    output logic oscIsRc,
    output logic clkDivTwo,
    output logic irqLevelTrig
);
    logic pinLevel;
    logic pinPrev;
    logic [1:0] cycDiv;
    logic [`PDT_PRESCALE_W-1:0] prescale;
    logic [`PDT_PRESCALE_W-1:0] next_prescale;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] optByte;
    logic [7:0] next_optByte;
    logic [7:0] ctrl;
    logic [5:0] ctrlKeep;
    logic [1:0] ctrlIrq;
    logic [`PDT_PRESCALE_W-1:0] prescaleInc;
    logic [7:0] next_ctrl;
    logic [31:0] next_prdata;
    logic [1:0] next_cycDiv;
    pdt_pkg::pdt_state_type state;
    pdt_pkg::pdt_state_type next_state;
    logic cycTick;
    logic step;
    logic tapPulse;
    logic access;
    logic wrCtrl;
    logic zeroHit;
    logic [11:0] regIdx;
    logic mapped;
    pdt_pkg::pdt_source_type src;

    pdt_pin_sync uSync (
        .clock(clock),
        .rst_n(rst_n),
        .pinIn(timerPin),
        .pinLevel(pinLevel)
    );

    // Instruction-cycle clock as a one-cycle enable at a fixed divide
    assign cycTick = (cycDiv == 2'(`PDT_INTCLK_DIV - 1));
    assign ctrl = {ctrlIrq, ctrlKeep};
    // Taps watch the plain increment so a prescaler clear never fakes a tap edge
    assign prescaleInc = prescale + 7'h01;
    assign src = pdt_pkg::pdt_source_type'({ctrl[`PDT_BIT_SRC], ctrl[`PDT_BIT_EXT]});

    always_comb begin
        case (src)
            pdt_pkg::PDT_SRC_INT: step = cycTick;
            pdt_pkg::PDT_SRC_AND: step = cycTick & pinLevel;
            pdt_pkg::PDT_SRC_OFF: step = 1'b0;
            pdt_pkg::PDT_SRC_PIN: step = pinPrev & ~pinLevel;
            default: step = 1'b0;
        endcase
        if (state != pdt_pkg::PDT_RUN) begin
            step = 1'b0;
        end
    end

    pdt_tap_select uTap (
        .prescaleNext(prescaleInc),
        .prescale(prescale),
        .tapSel(ctrl[2:0]),
        .step(step),
        .tapPulse(tapPulse)
    );

    assign regIdx = paddr[13:2];
    assign mapped = (paddr[1:0] == 2'h0) && ((regIdx == `PDT_CTRL_IDX)
        || (regIdx == `PDT_OPT_IDX) || (regIdx == `PDT_CNT_IDX)
        || (regIdx == `PDT_OPT_PROG_IDX)) && (paddr[31:14] == 18'h0);
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign wrCtrl = access & pwrite & pstrb[0] & (regIdx == `PDT_CTRL_IDX) & mapped;
    assign zeroHit = tapPulse & (count == 8'h01);

    always_comb begin
        next_cycDiv = cycTick ? 2'h0 : cycDiv + 2'h1;
        next_state = state;
        case (state)
            pdt_pkg::PDT_RUN: begin
                if (stopExec) begin
                    next_state = pdt_pkg::PDT_STOPPED;
                end
            end
            pdt_pkg::PDT_STOPPED: begin
                if (extIrqWake) begin
                    next_state = pdt_pkg::PDT_RUN;
                end
            end
            default: next_state = pdt_pkg::PDT_RUN;
        endcase
    end

    always_comb begin
        next_prescale = step ? prescaleInc : prescale;
        if ((wrCtrl && pwdata[`PDT_BIT_PCLR]) || stopExec) begin
            next_prescale = 7'h00;
        end
        next_count = tapPulse ? count - 8'h01 : count;
        if (access && pwrite && pstrb[0] && mapped && regIdx == `PDT_CNT_IDX) begin
            next_count = pwdata[7:0];
        end
        next_ctrl = ctrl;
        if (wrCtrl) begin
            next_ctrl = pwdata[7:0];
        end
        next_ctrl[`PDT_BIT_PCLR] = 1'b0;
        if (zeroHit) begin
            next_ctrl[`PDT_BIT_REQ] = 1'b1;
        end
        if (stopExec) begin
            next_ctrl[`PDT_BIT_REQ] = 1'b0;
            next_ctrl[`PDT_BIT_MASK] = 1'b1;
        end
        // Option byte is nonvolatile; only the programming path alters it
        next_optByte = optByte;
        if (access && pwrite && pstrb[0] && mapped && regIdx == `PDT_OPT_PROG_IDX
            && bootstrapMode) begin
            next_optByte = pwdata[7:0];
        end
    end

    always_comb begin
        next_prdata = 32'h0;
        case (regIdx)
            `PDT_CTRL_IDX: next_prdata = {24'h0, ctrl & 8'hF7};
            `PDT_OPT_IDX: next_prdata = {24'h0, optByte | `PDT_OPT_UNUSED};
            `PDT_CNT_IDX: next_prdata = {24'h0, count};
            default: next_prdata = 32'h0;
        endcase
        if (!(psel && !penable && !pwrite && mapped)) begin
            next_prdata = prdata;
        end
    end

    // Option byte lives outside the reset domain like the stored bits
    always_ff @(posedge clock) begin
        optByte <= next_optByte;
    end

    // Source, enable and select bits have no reset term
    always_ff @(posedge clock) begin
        ctrlKeep <= next_ctrl[5:0];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrlIrq <= 2'h1;
            // Matches the synchroniser reset level so no false fall follows reset
            pinPrev <= 1'b0;
            prescale <= 7'h00;
            count <= 8'hFF;
            cycDiv <= 2'h0;
            state <= pdt_pkg::PDT_RUN;
            prdata <= 32'h0;
        end else begin
            ctrlIrq <= next_ctrl[7:6];
            pinPrev <= pinLevel;
            prescale <= next_prescale;
            count <= next_count;
            cycDiv <= next_cycDiv;
            state <= next_state;
            prdata <= next_prdata;
        end
    end

    assign timerIrq = ctrl[`PDT_BIT_REQ] & ~ctrl[`PDT_BIT_MASK] & ~cpuIrqMask;
    // Bootstrap overrides clock settings only
    assign oscIsRc = ~bootstrapMode & optByte[`PDT_BIT_OSC];
    assign clkDivTwo = ~bootstrapMode & optByte[`PDT_BIT_DIV];
    assign irqLevelTrig = optByte[`PDT_BIT_TRIG];
endmodule : pdt_timer

/* pdt_timer_checker.sv */
`timescale 1ns/1ps
module pdt_timer_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stopExec,
    input wire logic cpuIrqMask,
    input wire logic bootstrapMode,
    input wire logic timerIrq,
    input wire logic oscIsRc,
    input wire logic clkDivTwo,
    input wire logic irqLevelTrig
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic rdAcc;
    logic hit;
    assign acc = psel && penable;
    assign rdAcc = acc && !pwrite;
    assign hit = paddr inside {32'h20, 32'h24, 32'h1FD4, 32'h400};
    chk_ready_no_wait: assert property (acc |-> pready)
        else $error("pready low in access");
    chk_err_unmapped: assert property (acc |-> pslverr == !hit)
        else $error("pslverr wrong");
    chk_ctrl_bit3: assert property (rdAcc && paddr == 32'h24 |-> !prdata[3])
        else $error("control bit 3 read as one");
    chk_upper_zero: assert property (rdAcc && hit |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_opt_ones: assert property (rdAcc && paddr == 32'h1FD4
        |-> prdata[5] && prdata[3:0] == 4'hF)
        else $error("unused option bits not one");
    chk_irq_cpu: assert property (timerIrq |-> !cpuIrqMask)
        else $error("irq while processor masked");
    chk_stop_quiet: assert property (stopExec |=> !timerIrq [*2])
        else $error("irq after stop");
    chk_reset_quiet: assert property ($rose(rst_n) |-> !timerIrq)
        else $error("irq after reset");
    chk_boot_force: assert property (bootstrapMode |-> !oscIsRc && !clkDivTwo)
        else $error("bootstrap not forcing oscillator");
    chk_trig_keep: assert property ($changed(bootstrapMode) && !$past(acc && pwrite)
        |-> $stable(irqLevelTrig))
        else $error("trigger follows bootstrap");
    cover property (stopExec);
    cover property (acc && pslverr);
    cover property (timerIrq);
endmodule : pdt_timer_checker
bind pdt_timer pdt_timer_checker chk_u (.clock, .rst_n, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .stopExec, .cpuIrqMask, .bootstrapMode, .timerIrq, .oscIsRc,
    .clkDivTwo, .irqLevelTrig);

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t got %h expected %h", $time, a, b); end end
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic stopExec = 1'b0, extIrqWake = 1'b0, cpuIrqMask = 1'b0, bootstrapMode = 1'b1;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, timerPin, timerIrq, oscIsRc, clkDivTwo, irqLevelTrig, err;
    logic [1:0] pinMode = 2'h0;
    logic [7:0] d;
    int errors = 0, checks_done = 0, cycles = 0;
    always #2.5 clock = ~clock;
    pdt_timer dut_u (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .timerPin, .stopExec, .extIrqWake,
        .cpuIrqMask, .bootstrapMode, .timerIrq, .oscIsRc, .clkDivTwo, .irqLevelTrig);
    pdt_pin_model pin_u (.clock, .pinMode, .pin(timerPin));
    task automatic end_of_test();
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("mismatch %0t timeout", $time);
            end_of_test();
        end
    end
    // Ends one idle edge later so outputs have settled and psel is never driven twice a step
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dt);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    // Counter drop between two reads whose setups are n cycles apart
    task automatic span(input int n);
        logic [7:0] c0;
        apb(1'b0, 32'h20, 32'h0);
        c0 = rd[7:0];
        repeat (n - 3) @(posedge clock);
        apb(1'b0, 32'h20, 32'h0);
        d = 8'(c0 - rd[7:0]);
    endtask : span
    task automatic t_opt();
        apb(1'b1, 32'h400, 32'hD0);
        apb(1'b1, 32'h1FD4, 32'h0);
        apb(1'b0, 32'h1FD4, 32'h0);
        `CHK(rd[7:0], 8'hFF)
        `CHK({oscIsRc, clkDivTwo, irqLevelTrig}, 3'h1)
        bootstrapMode <= 1'b0;
        apb(1'b1, 32'h400, 32'h0);
        `CHK({oscIsRc, clkDivTwo, irqLevelTrig}, 3'h7)
        bootstrapMode <= 1'b1;
        apb(1'b1, 32'h400, 32'h0);
        bootstrapMode <= 1'b0;
        apb(1'b0, 32'h1FD4, 32'h0);
        `CHK(rd[7:0], 8'h2F)
        `CHK({oscIsRc, clkDivTwo, irqLevelTrig}, 3'h0)
    endtask : t_opt
    task automatic t_regs();
        apb(1'b1, 32'h24, 32'h38);
        apb(1'b0, 32'h24, 32'h0);
        `CHK(rd[7:0], 8'h30)
        apb(1'b0, 32'h44, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 32'h24, 32'hA0);
        `CHK(timerIrq, 1'b1)
        cpuIrqMask <= 1'b1;
        @(posedge clock);
        `CHK(timerIrq, 1'b0)
        cpuIrqMask <= 1'b0;
        apb(1'b1, 32'h24, 32'hE0);
        `CHK(timerIrq, 1'b0)
        apb(1'b1, 32'h24, 32'h20);
        apb(1'b0, 32'h24, 32'h0);
        `CHK(rd[7:0], 8'h20)
    endtask : t_regs
    task automatic t_div();
        apb(1'b1, 32'h20, 32'h2);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 32'h24, 32'h40 | 32'(s));
            span(16 << s);
            `CHK(d, 8'h4)
        end
    endtask : t_div
    task automatic t_modes();
        logic [7:0] m [6] = '{8'h40, 8'h50, 8'h50, 8'h60, 8'h70, 8'h70};
        logic [1:0] p [6] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
        logic [7:0] e [6] = '{8'h10, 8'h10, 8'h0, 8'h0, 8'h4, 8'h0};
        for (int i = 0; i < 6; i++) begin
            pinMode <= p[i];
            apb(1'b1, 32'h24, {24'h0, m[i]});
            repeat (8) @(posedge clock);
            span(64);
            `CHK(d, e[i])
        end
    endtask : t_modes
    task automatic t_stop();
        apb(1'b1, 32'h20, 32'h3);
        apb(1'b1, 32'h24, 32'h0);
        for (int i = 0; i < 200 && timerIrq !== 1'b1; i++) @(posedge clock);
        `CHK(timerIrq, 1'b1)
        stopExec <= 1'b1;
        @(posedge clock);
        stopExec <= 1'b0;
        apb(1'b0, 32'h24, 32'h0);
        `CHK(rd[7:0], 8'h40)
        span(64);
        `CHK(d, 8'h0)
        extIrqWake <= 1'b1;
        @(posedge clock);
        extIrqWake <= 1'b0;
        span(64);
        `CHK(d, 8'h10)
    endtask : t_stop
    task automatic t_keep();
        apb(1'b1, 32'h24, 32'h3D);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, 32'h24, 32'h0);
        `CHK(rd[7:0], 8'h75)
    endtask : t_keep
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_opt();
        t_regs();
        t_div();
        t_modes();
        t_stop();
        t_keep();
        end_of_test();
    end
endmodule : testbench
